// [design/vic_pkg.sv]
// package of constants and carrier types for the video interrupt controller
// assumes an 8-bit register port with a map select, all on the MCLK_IN domain
// Behaviour
// - level raw bits mirror their live condition
// - edge raw bits latch until their clear
// - pll lock, clock, encryption, cable power are level
// - key vector, link check, frequency, clock, measure are edge
// - further events keep one single asserted output
// - store mode sets status without mask, no pin
// - stored status holds until cleared; default needs mask
// - transmitter flags set on event, write one clears
// - both transmitters behave identically
// - hot plug flag is bit seven, resets zero
// - masked raw change sets status and interrupts
// - clear bit writes one to clear, self clearing
// - transmitter output needs flag and mask both set
package vic_pkg;

    // register maps selected by the map select port
    localparam logic [1:0] VIC_MAP_IO  = 2'h0;
    localparam logic [1:0] VIC_MAP_TXA = 2'h1;
    localparam logic [1:0] VIC_MAP_TXB = 2'h2;

    // io map
    localparam logic [7:0] VIC_CTL_SRC_ADDR   = 8'h3f;
    localparam logic [7:0] VIC_CTL_CFG_ADDR   = 8'h40;
    localparam int         VIC_STORE_BIT      = 4;
    localparam logic       VIC_STORE_RESET    = 1'b0;

    // receiver groups: raw, status, clear and mask at fixed offsets from a base
    localparam int              VIC_RX_GROUPS = 4;
    localparam logic [3:0][7:0] VIC_RX_BASE   = {8'h72, 8'h6c, 8'h66, 8'h60};
    localparam logic [3:0][7:0] VIC_RX_LEVEL  = {8'h00, 8'h00, 8'hff, 8'hff};
    localparam logic [7:0]      VIC_RAW_OFS   = 8'h00;
    localparam logic [7:0]      VIC_ST_OFS    = 8'h01;
    localparam logic [7:0]      VIC_CLR_OFS   = 8'h02;
    localparam logic [7:0]      VIC_MB_OFS    = 8'h04;

    // group 3 bit positions
    localparam int VIC_FREQ_BIT = 0;
    localparam int VIC_VCLK_BIT = 1;
    localparam int VIC_MEAS_BIT = 2;

    // transmitter main map
    localparam logic [7:0] VIC_TX_MB_ADDR  = 8'h94;
    localparam logic [7:0] VIC_TX_ST_ADDR  = 8'h96;
    localparam int         VIC_TX_HPD_BIT  = 7;
    localparam logic [7:0] VIC_BYTE_RESET  = 8'h00;
    localparam int         VIC_LEVEL_SRCS  = 16;

    typedef struct packed {
        logic [7:0] raw;
        logic [7:0] st;
        logic [7:0] mb;
    } vic_grp_t;

    typedef struct packed {
        logic [1:0] map;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } vic_req_t;

    typedef struct packed {
        logic [VIC_LEVEL_SRCS-1:0] sync1;
        logic [VIC_LEVEL_SRCS-1:0] sync2;
        logic                      store;
        logic [7:0]                rdata;
        logic                      rvalid;
        logic                      pin;
    } vic_top_t;

endpackage : vic_pkg

// [design/vic_irq_group.sv]
// one group of eight interrupt sources with raw, status and mask bytes
// assumes sources are synchronous to clk_in; clear vector is a one-cycle pulse
`timescale 1ns/1ps
module vic_irq_group import vic_pkg::*; #(
    parameter logic [7:0] LEVEL_BITS   = 8'h00,
    parameter logic       STORE_ALWAYS = 1'b0
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [7:0] src_in,
    input  wire logic       store_all_in,
    input  wire logic       mask_we_in,
    input  wire logic       clr_we_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] raw_out,
    output logic      [7:0] st_out,
    output logic      [7:0] mb_out,
    output logic            irq_out
);

    vic_grp_t   s_q;
    vic_grp_t   s_d;
    logic [7:0] clr_vec;
    logic [7:0] chg;
    logic [7:0] set_vec;

    always_comb begin
        clr_vec = clr_we_in ? wdata_in : VIC_BYTE_RESET;
        // level bits report any change, edge bits report the pulse itself
        chg     = (LEVEL_BITS & (src_in ^ s_q.raw)) | (~LEVEL_BITS & src_in);
        set_vec = chg & (s_q.mb | {8{store_all_in | STORE_ALWAYS}});
        s_d     = s_q;
        s_d.raw = (LEVEL_BITS & src_in)
                | (~LEVEL_BITS & (src_in | (s_q.raw & ~clr_vec)));
        s_d.st  = set_vec | (s_q.st & ~clr_vec);
        if (mask_we_in) begin
            s_d.mb = wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_q <= '{raw: VIC_BYTE_RESET, st: VIC_BYTE_RESET, mb: VIC_BYTE_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign raw_out = s_q.raw;
    assign st_out  = s_q.st;
    assign mb_out  = s_q.mb;
    assign irq_out = |(s_q.st & s_q.mb);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    level_mirror_a: assert property (
        1 |=> ((raw_out & LEVEL_BITS) == ($past(src_in) & LEVEL_BITS)))
        else $error("level raw bit does not follow its source");

    edge_latch_a: assert property (
        (|(src_in & ~LEVEL_BITS)) |=> ((raw_out & $past(src_in) & ~LEVEL_BITS) == ($past(src_in) & ~LEVEL_BITS)))
        else $error("edge event not latched in raw bit");

    edge_hold_a: assert property (
        1 |=> ((~LEVEL_BITS & $past(raw_out) & ~$past(clr_vec) & ~raw_out) == 8'h00))
        else $error("edge raw bit dropped without clear");

    status_set_a: assert property (
        (|(chg & s_q.mb)) |=> ((st_out & $past(chg & s_q.mb)) == $past(chg & s_q.mb)))
        else $error("masked change did not set status");

    status_hold_a: assert property (
        1 |=> (($past(st_out) & ~$past(clr_vec) & ~st_out) == 8'h00))
        else $error("status fell without its clear");

    status_mask_a: assert property (
        (!store_all_in && !STORE_ALWAYS) |=> ((st_out & ~$past(st_out) & ~$past(mb_out)) == 8'h00))
        else $error("status set without mask in default mode");

    stored_quiet_a: assert property (
        (store_all_in && (mb_out == 8'h00) && !mask_we_in) |=> !irq_out)
        else $error("unmasked stored status drives interrupt");

endmodule : vic_irq_group

// [design/vic_top.sv]
// interrupt controller: four receiver groups, two transmitter sections, one pin
// assumes register port and event pulses run on MCLK_IN; level conditions are asynchronous
`timescale 1ns/1ps
module vic_top import vic_pkg::*; (
    input  wire logic       MCLK_IN,
    input  wire logic       RST_B_IN,
    input  wire logic [1:0] REG_MAP_SEL_IN,
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    input  wire logic [3:0] PORT_LINK_PLL_LOCK_LIVE_IN,
    input  wire logic [3:0] PORT_LINK_CLOCK_PRESENT_IN,
    input  wire logic [3:0] PORT_ENCRYPTION_ACTIVE_IN,
    input  wire logic [3:0] PORT_CABLE_POWER_SEEN_IN,
    input  wire logic [3:0] PORT_KEY_VECTOR_WRITTEN_IN,
    input  wire logic [3:0] PORT_LINK_CHECK_EXPIRED_IN,
    input  wire logic       LINK_FREQUENCY_CHANGED_EVENT_IN,
    input  wire logic       VIDEO_CLOCK_CHANGE_EVENT_IN,
    input  wire logic       BACKGROUND_MEASURE_DONE_EVENT_IN,
    input  wire logic [7:0] FIRST_TRANSMITTER_EVENTS_IN,
    input  wire logic [7:0] SECOND_TRANSMITTER_EVENTS_IN,
    output logic      [7:0] REG_RDATA_OUT,
    output logic            REG_RDATA_VALID_OUT,
    output logic            PRIMARY_INTERRUPT_OUT
);

    vic_top_t              s_q;
    vic_top_t              s_d;
    vic_req_t              req;
    logic [3:0][7:0]       rx_src;
    logic [3:0][7:0]       rx_raw;
    logic [3:0][7:0]       rx_st;
    logic [3:0][7:0]       rx_mb;
    logic [3:0]            rx_grp_irq;
    logic [3:0]            rx_mask_we;
    logic [3:0]            rx_clr_we;
    logic [7:0]            txa_st;
    logic [7:0]            txa_mb;
    logic [7:0]            txb_st;
    logic [7:0]            txb_mb;
    logic                  txa_irq;
    logic                  txb_irq;
    logic                  rx_irq;
    logic                  io_wr;
    logic                  txa_wr;
    logic                  txb_wr;
    logic [7:0]            rd_mux;

    assign req = '{map: REG_MAP_SEL_IN, addr: REG_ADDR_IN, wdata: REG_WDATA_IN,
                   wr: REG_WR_IN, rd: REG_RD_IN};

    // level conditions arrive asynchronously, so only the second stage feeds the groups
    // one process drives every group source so the packed array has a single driver
    always_comb begin
        rx_src[0]               = {s_q.sync2[7:4], s_q.sync2[3:0]};
        rx_src[1]               = {s_q.sync2[15:12], s_q.sync2[11:8]};
        rx_src[2]               = {PORT_LINK_CHECK_EXPIRED_IN, PORT_KEY_VECTOR_WRITTEN_IN};
        rx_src[3]               = VIC_BYTE_RESET;
        rx_src[3][VIC_FREQ_BIT] = LINK_FREQUENCY_CHANGED_EVENT_IN;
        rx_src[3][VIC_VCLK_BIT] = VIDEO_CLOCK_CHANGE_EVENT_IN;
        rx_src[3][VIC_MEAS_BIT] = BACKGROUND_MEASURE_DONE_EVENT_IN;
    end

    assign io_wr  = req.wr && (req.map == VIC_MAP_IO);
    assign txa_wr = req.wr && (req.map == VIC_MAP_TXA);
    assign txb_wr = req.wr && (req.map == VIC_MAP_TXB);

    always_comb begin
        for (int g = 0; g < VIC_RX_GROUPS; g++) begin
            rx_mask_we[g] = io_wr && (req.addr == (VIC_RX_BASE[g] + VIC_MB_OFS));
            rx_clr_we[g]  = io_wr && (req.addr == (VIC_RX_BASE[g] + VIC_CLR_OFS));
        end
    end

    for (genvar g = 0; g < VIC_RX_GROUPS; g++) begin : g_rx
        vic_irq_group #(
            .LEVEL_BITS   (VIC_RX_LEVEL[g]),
            .STORE_ALWAYS (1'b0)
        ) u_grp (
            .clk_in       (MCLK_IN),
            .rst_b_in     (RST_B_IN),
            .src_in       (rx_src[g]),
            .store_all_in (s_q.store),
            .mask_we_in   (rx_mask_we[g]),
            .clr_we_in    (rx_clr_we[g]),
            .wdata_in     (req.wdata),
            .raw_out      (rx_raw[g]),
            .st_out       (rx_st[g]),
            .mb_out       (rx_mb[g]),
            .irq_out      (rx_grp_irq[g])
        );
    end

    // transmitter flags latch on every event; masks only gate the section output
    vic_irq_group #(
        .LEVEL_BITS   (8'h00),
        .STORE_ALWAYS (1'b1)
    ) u_txa (
        .clk_in       (MCLK_IN),
        .rst_b_in     (RST_B_IN),
        .src_in       (FIRST_TRANSMITTER_EVENTS_IN),
        .store_all_in (1'b0),
        .mask_we_in   (txa_wr && (req.addr == VIC_TX_MB_ADDR)),
        .clr_we_in    (txa_wr && (req.addr == VIC_TX_ST_ADDR)),
        .wdata_in     (req.wdata),
        .raw_out      (),
        .st_out       (txa_st),
        .mb_out       (txa_mb),
        .irq_out      (txa_irq)
    );

    vic_irq_group #(
        .LEVEL_BITS   (8'h00),
        .STORE_ALWAYS (1'b1)
    ) u_txb (
        .clk_in       (MCLK_IN),
        .rst_b_in     (RST_B_IN),
        .src_in       (SECOND_TRANSMITTER_EVENTS_IN),
        .store_all_in (1'b0),
        .mask_we_in   (txb_wr && (req.addr == VIC_TX_MB_ADDR)),
        .clr_we_in    (txb_wr && (req.addr == VIC_TX_ST_ADDR)),
        .wdata_in     (req.wdata),
        .raw_out      (),
        .st_out       (txb_st),
        .mb_out       (txb_mb),
        .irq_out      (txb_irq)
    );

    assign rx_irq = |rx_grp_irq;

    // clear registers always read back zero since they self clear
    always_comb begin
        rd_mux = VIC_BYTE_RESET;
        if (req.map == VIC_MAP_IO) begin
            if (req.addr == VIC_CTL_SRC_ADDR) begin
                rd_mux = {5'h00, ~txb_irq, ~txa_irq, rx_irq};
            end else if (req.addr == VIC_CTL_CFG_ADDR) begin
                rd_mux[VIC_STORE_BIT] = s_q.store;
            end else begin
                for (int g = 0; g < VIC_RX_GROUPS; g++) begin
                    if (req.addr == (VIC_RX_BASE[g] + VIC_RAW_OFS)) begin
                        rd_mux = rx_raw[g];
                    end else if (req.addr == (VIC_RX_BASE[g] + VIC_ST_OFS)) begin
                        rd_mux = rx_st[g];
                    end else if (req.addr == (VIC_RX_BASE[g] + VIC_MB_OFS)) begin
                        rd_mux = rx_mb[g];
                    end
                end
            end
        end else if (req.map == VIC_MAP_TXA) begin
            if (req.addr == VIC_TX_ST_ADDR) begin
                rd_mux = txa_st;
            end else if (req.addr == VIC_TX_MB_ADDR) begin
                rd_mux = txa_mb;
            end
        end else if (req.map == VIC_MAP_TXB) begin
            if (req.addr == VIC_TX_ST_ADDR) begin
                rd_mux = txb_st;
            end else if (req.addr == VIC_TX_MB_ADDR) begin
                rd_mux = txb_mb;
            end
        end
    end

    always_comb begin
        s_d        = s_q;
        s_d.sync1  = {PORT_CABLE_POWER_SEEN_IN, PORT_ENCRYPTION_ACTIVE_IN,
                      PORT_LINK_CLOCK_PRESENT_IN, PORT_LINK_PLL_LOCK_LIVE_IN};
        s_d.sync2  = s_q.sync1;
        s_d.rvalid = req.rd;
        if (req.rd) begin
            s_d.rdata = rd_mux;
        end
        if (io_wr && (req.addr == VIC_CTL_CFG_ADDR)) begin
            s_d.store = req.wdata[VIC_STORE_BIT];
        end
        // one level output: later events while it is high do not pulse it again
        s_d.pin    = rx_irq | txa_irq | txb_irq;
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s_q <= '{sync1: '0, sync2: '0, store: VIC_STORE_RESET, rdata: VIC_BYTE_RESET,
                     rvalid: 1'b0, pin: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA_OUT         = s_q.rdata;
    assign REG_RDATA_VALID_OUT   = s_q.rvalid;
    assign PRIMARY_INTERRUPT_OUT = s_q.pin;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_B_IN);

    level_sync_a: assert property (
        1 |=> ##2 (rx_raw[0] == $past({PORT_LINK_CLOCK_PRESENT_IN, PORT_LINK_PLL_LOCK_LIVE_IN}, 3)))
        else $error("level group raw byte not three cycles behind its inputs");

    edge_class_a: assert property (
        (PORT_KEY_VECTOR_WRITTEN_IN[0] && !rx_clr_we[2]) |=> rx_raw[2][0] ##1 (rx_raw[2][0] || $past(rx_clr_we[2])))
        else $error("key vector event not latched as edge");

    pin_rise_a: assert property (
        $rose(rx_irq || txa_irq || txb_irq) |=> PRIMARY_INTERRUPT_OUT)
        else $error("pin not raised after an enabled event");

    pin_single_a: assert property (
        (PRIMARY_INTERRUPT_OUT && rx_irq) |=> PRIMARY_INTERRUPT_OUT)
        else $error("pin dropped while an enabled event is uncleared");

    store_ctl_a: assert property (
        (io_wr && req.addr == VIC_CTL_CFG_ADDR) |=> (s_q.store == $past(req.wdata[VIC_STORE_BIT])))
        else $error("store control not written");

    hot_plug_a: assert property (
        FIRST_TRANSMITTER_EVENTS_IN[VIC_TX_HPD_BIT] |=> txa_st[VIC_TX_HPD_BIT])
        else $error("hot plug event did not set flag bit seven");

    tx_w1c_a: assert property (
        (txa_wr && req.addr == VIC_TX_ST_ADDR && (FIRST_TRANSMITTER_EVENTS_IN == 8'h00))
        |=> ((txa_st & $past(req.wdata)) == 8'h00))
        else $error("write one did not clear transmitter flag");

    tx_mask_a: assert property (
        (txa_mb == 8'h00 && !txa_wr) |=> !txa_irq ##0 (txa_st == ($past(txa_st) | $past(FIRST_TRANSMITTER_EVENTS_IN))))
        else $error("transmitter mask disturbs flags or output");

    tx_twin_a: assert property (
        (FIRST_TRANSMITTER_EVENTS_IN == SECOND_TRANSMITTER_EVENTS_IN && !txa_wr && !txb_wr
         && txa_st == txb_st && txa_mb == txb_mb) |=> (txa_st == txb_st && txa_irq == txb_irq))
        else $error("transmitter sections diverge");

    pin_rx_c:    cover property ($rose(PRIMARY_INTERRUPT_OUT) && rx_irq);
    stored_c:    cover property (s_q.store && (|rx_st[1]) && !PRIMARY_INTERRUPT_OUT);
    hot_plug_c:  cover property (txa_st[VIC_TX_HPD_BIT] ##[1:20] !txa_st[VIC_TX_HPD_BIT]);
    all_three_c: cover property (rx_irq && txa_irq && txb_irq);

endmodule : vic_top

// [testbench/vic_host_model.sv]
// host model: register port master that services the interrupt pin
// assumes the bench calls its tasks one at a time; strobes change on the falling edge
`timescale 1ns/1ps
module vic_host_model import vic_pkg::*; #(
    parameter int PRIMARY = 0
) (
    input  wire logic       clk_in,
    input  wire logic       irq_in,
    input  wire logic       rvalid_in,
    input  wire logic [7:0] rdata_in,
    output vic_req_t        req_out
);
    initial req_out = '0;

    task automatic acc(input logic [1:0] map, input logic [7:0] addr, input logic [7:0] wdata,
                       input logic wr, output logic [7:0] rdata);
        int n;
        rdata = 8'h00;
        @(negedge clk_in);
        req_out = '{map: map, addr: addr, wdata: wdata, wr: wr, rd: ~wr};
        @(negedge clk_in);
        // released lines carry the inverse so a stale value never passes for a request
        req_out = '{map: ~map, addr: ~addr, wdata: ~wdata, wr: 1'b0, rd: 1'b0};
        for (n = 0; n < 4 && rvalid_in !== 1'b1 && !wr; n++) begin
            @(posedge clk_in);
            #1;
        end
        rdata = rdata_in;
    endtask : acc

    // every receiver group status byte is read on each interrupt, several flags may stand at once
    task automatic service(output logic [3:0][7:0] st, output logic [3:0][7:0] ok);
        logic [7:0] raw;
        logic       act;
        for (int n = 0; n < 16 && irq_in !== 1'b1; n++) @(posedge clk_in);
        for (int g = 0; g < VIC_RX_GROUPS; g++) acc(VIC_MAP_IO, VIC_RX_BASE[g] + VIC_ST_OFS, 8'h00, 1'b0, st[g]);
        acc(VIC_MAP_IO, VIC_RX_BASE[0] + VIC_RAW_OFS, 8'h00, 1'b0, raw);
        act = raw[4 + PRIMARY];
        // flags are acted on only once their validity holds
        ok[0] = {st[0][7:4], st[0][3:0] & raw[7:4]};
        ok[1] = {st[1][7:4], act ? st[1][3:0] : 4'h0};
        ok[2] = {act ? st[2][7:4] : 4'h0, st[2][3:0]};
        ok[3] = {st[3][7:2], act ? st[3][1:0] : 2'h0};
    endtask : service
endmodule : vic_host_model

// [testbench/vic_top_tb.sv]
// testbench of the video interrupt controller with a host model on the register port
// assumes the design answers reads one cycle after the strobe edge
`timescale 1ns/1ps
module vic_top_tb import vic_pkg::*; ;
    logic            mclk = 1'b0;
    logic            rst_b;
    logic [3:0]      pll, clkp, enc, cab, kv, lc;
    logic [2:0]      g3;
    logic [1:0][7:0] tx_ev;
    vic_req_t        req;
    logic [7:0]      rdata, r, s, p;
    logic            rvalid, irq;
    logic [3:0][7:0] st, ok;
    logic [7:0]      notes[$];
    logic [7:0]      lfsr = 8'h4b;
    int              miscompares = 0;
    int              checked = 0;

    vic_top vic_top_i (.MCLK_IN(mclk), .RST_B_IN(rst_b), .REG_MAP_SEL_IN(req.map), .REG_ADDR_IN(req.addr),
        .REG_WDATA_IN(req.wdata), .REG_WR_IN(req.wr), .REG_RD_IN(req.rd), .PORT_LINK_PLL_LOCK_LIVE_IN(pll),
        .PORT_LINK_CLOCK_PRESENT_IN(clkp), .PORT_ENCRYPTION_ACTIVE_IN(enc), .PORT_CABLE_POWER_SEEN_IN(cab),
        .PORT_KEY_VECTOR_WRITTEN_IN(kv), .PORT_LINK_CHECK_EXPIRED_IN(lc), .LINK_FREQUENCY_CHANGED_EVENT_IN(g3[0]),
        .VIDEO_CLOCK_CHANGE_EVENT_IN(g3[1]), .BACKGROUND_MEASURE_DONE_EVENT_IN(g3[2]),
        .FIRST_TRANSMITTER_EVENTS_IN(tx_ev[0]), .SECOND_TRANSMITTER_EVENTS_IN(tx_ev[1]),
        .REG_RDATA_OUT(rdata), .REG_RDATA_VALID_OUT(rvalid), .PRIMARY_INTERRUPT_OUT(irq));
    vic_host_model vic_host_model_i (.clk_in(mclk), .irq_in(irq), .rvalid_in(rvalid), .rdata_in(rdata),
        .req_out(req));

    initial forever #4 mclk = ~mclk;

    task automatic finish_test();
        // a read whose valid never came leaves its note behind
        cmp("pending reads", 8'h00, 8'(notes.size()));
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic rd(input logic [1:0] m, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        notes.push_back(exp);
        vic_host_model_i.acc(m, a, 8'h00, 1'b0, got);
    endtask : rd

    task automatic wr(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] got;
        vic_host_model_i.acc(m, a, d, 1'b1, got);
    endtask : wr

    task automatic rdx(input int g, input logic [7:0] ofs, input logic [7:0] exp);
        rd(VIC_MAP_IO, VIC_RX_BASE[g] + ofs, exp);
    endtask : rdx

    task automatic wrx(input int g, input logic [7:0] ofs, input logic [7:0] d);
        wr(VIC_MAP_IO, VIC_RX_BASE[g] + ofs, d);
    endtask : wrx

    // one-cycle event pulses, as the event inputs expect
    task automatic ev(input logic [3:0] k, input logic [3:0] l, input logic [2:0] f, input logic [1:0][7:0] t);
        @(negedge mclk);
        {kv, lc, g3, tx_ev} = {k, l, f, t};
        @(negedge mclk);
        {kv, lc, g3, tx_ev} = '0;
    endtask : ev

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic pin(input logic exp);
        cmp("interrupt pin", {7'h00, exp}, {7'h00, irq});
    endtask : pin

    function automatic logic [7:0] nxt();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : nxt

    always @(posedge mclk) begin
        #1;
        if (rvalid === 1'b1) begin
            if (notes.size() > 0) cmp("read data", notes.pop_front(), rdata);
            else cmp("read valid", 8'h00, 8'h01);
        end
    end

    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        {pll, clkp, enc, cab, kv, lc, g3, tx_ev} = '0;
        cyc(10);
        rst_b = 1'b1;
        rd(VIC_MAP_IO, VIC_CTL_CFG_ADDR, 8'h00);
        rd(VIC_MAP_IO, VIC_CTL_SRC_ADDR, 8'h06);
        rd(VIC_MAP_TXA, VIC_TX_ST_ADDR, VIC_BYTE_RESET);
        rd(VIC_MAP_TXB, VIC_TX_ST_ADDR, VIC_BYTE_RESET);
        rd(VIC_MAP_IO, 8'hff, 8'h00);
        // level sources follow the live inputs both ways without any clear
        r = nxt();
        s = nxt();
        @(negedge mclk);
        {clkp, pll, cab, enc} = {r, s};
        cyc(6);
        rdx(0, VIC_RAW_OFS, r);
        rdx(1, VIC_RAW_OFS, s);
        rdx(1, VIC_ST_OFS, 8'h00);
        {clkp, pll, cab, enc} = '0;
        cyc(6);
        rdx(0, VIC_RAW_OFS, 8'h00);
        pin(1'b0);
        // edge sources latch until their clear
        r = nxt();
        ev(r[3:0], r[7:4], 3'h7, '0);
        cyc(4);
        rdx(2, VIC_RAW_OFS, r);
        rdx(3, VIC_RAW_OFS, 8'h07);
        wrx(2, VIC_CLR_OFS, r);
        wrx(3, VIC_CLR_OFS, 8'h07);
        rdx(2, VIC_RAW_OFS, 8'h00);
        rdx(2, VIC_CLR_OFS, 8'h00);
        // masked sources raise the pin and stay single while more events come
        wrx(0, VIC_MB_OFS, 8'h10);
        wrx(2, VIC_MB_OFS, 8'hff);
        @(negedge mclk);
        clkp = 4'h1;
        p = nxt();
        ev(p[3:0], p[7:4], 3'h0, '0);
        cyc(6);
        pin(1'b1);
        rd(VIC_MAP_IO, VIC_CTL_SRC_ADDR, 8'h07);
        notes.push_back(8'h10);
        notes.push_back(8'h00);
        notes.push_back(p);
        notes.push_back(8'h00);
        notes.push_back(8'h10);
        vic_host_model_i.service(st, ok);
        cmp("accepted group0", 8'h10, ok[0]);
        cmp("accepted group2", p, ok[2]);
        ev(4'hf, 4'hf, 3'h0, '0);
        repeat (4) begin
            @(negedge mclk);
            pin(1'b1);
        end
        wrx(2, VIC_CLR_OFS, 8'h00);
        rdx(2, VIC_ST_OFS, 8'hff);
        wrx(2, VIC_CLR_OFS, 8'h0f);
        cyc(3);
        pin(1'b1);
        rdx(2, VIC_ST_OFS, 8'hf0);
        wrx(2, VIC_CLR_OFS, 8'hf0);
        wrx(0, VIC_CLR_OFS, 8'h10);
        cyc(3);
        pin(1'b0);
        wrx(2, VIC_CLR_OFS, 8'hff);
        // store mode keeps unmasked flags readable but away from the pin
        wr(VIC_MAP_IO, VIC_CTL_CFG_ADDR, 8'h10);
        rd(VIC_MAP_IO, VIC_CTL_CFG_ADDR, 8'h10);
        for (int k = 0; k < 2; k++) begin
            ev(4'h0, 4'h0, 3'h1, '0);
            cyc(8);
            rdx(3, VIC_ST_OFS, 8'h01);
            pin(1'b0);
            wrx(3, VIC_CLR_OFS, 8'h07);
            rdx(3, VIC_ST_OFS, 8'h00);
        end
        wr(VIC_MAP_IO, VIC_CTL_CFG_ADDR, 8'h00);
        ev(4'h0, 4'h0, 3'h1, '0);
        rdx(3, VIC_ST_OFS, 8'h00);
        // both transmitters: flags set without mask, pin needs the mask, write one clears
        for (int t = 0; t < 2; t++) begin
            tx_ev = '0;
            p = (nxt() & 8'he7) | 8'h80;
            ev(4'h0, 4'h0, 3'h0, t ? {p, 8'h00} : {8'h00, p});
            rd(2'(t + 1), VIC_TX_ST_ADDR, p);
            pin(1'b0);
            wr(2'(t + 1), VIC_TX_MB_ADDR, 8'h80);
            cyc(3);
            pin(1'b1);
            rd(VIC_MAP_IO, VIC_CTL_SRC_ADDR, t ? 8'h02 : 8'h04);
            wr(2'(t + 1), VIC_TX_ST_ADDR, 8'h7f);
            rd(2'(t + 1), VIC_TX_ST_ADDR, 8'h80);
            wr(2'(t + 1), VIC_TX_ST_ADDR, 8'h80);
            cyc(3);
            pin(1'b0);
            wr(2'(t + 1), VIC_TX_MB_ADDR, 8'h00);
        end
        cyc(4);
        finish_test();
    end
endmodule : vic_top_tb
